// ==== inc/ssf_pkg.sv ====
/*
 package of the serial port status flag block: register offsets, field
 positions, reset values and mode encodings.
 assumes a 32-bit apb slave with one aligned word per register.
*/
`default_nettype none
package ssf_pkg;
	// -------------------------------------------------------------
	// register byte offsets
	// -------------------------------------------------------------
	localparam logic [7:0] off_status = 8'h00;
	localparam logic [7:0] off_control = 8'h04;
	localparam logic [7:0] off_data = 8'h08;
	localparam logic [7:0] off_address = 8'h0c;
	localparam logic [7:0] off_int_status = 8'h10;
	localparam logic [7:0] off_int_mask = 8'h14;
	// -------------------------------------------------------------
	// serial_status fields
	// -------------------------------------------------------------
	localparam int st_rw_bit = 2;
	localparam int st_update_address_flag = 1;
	localparam int st_buffer_full_flag = 0;
	// -------------------------------------------------------------
	// serial_control fields
	// -------------------------------------------------------------
	localparam int ct_write_collision_flag = 7;
	localparam int ct_receive_overflow_flag = 6;
	localparam int ct_port_enable_bit = 5;
	localparam int ct_clock_polarity_bit = 4;
	localparam logic [7:0] control_reset = 8'h00;
	// -------------------------------------------------------------
	// port mode encodings
	// -------------------------------------------------------------
	localparam logic [2:0] mode_i2c_prefix = 3'h3;
	localparam logic [3:0] mode_i2c_10bit = 4'h7;
	// -------------------------------------------------------------
	// interrupt status / mask fields
	// -------------------------------------------------------------
	localparam int irq_rx_done = 0;
	localparam int irq_tx_done = 1;
	localparam int irq_collision = 2;
	localparam int irq_update_address = 3;
	localparam int irq_count = 4;
	localparam logic [7:0] data_reset = 8'h00;
	localparam logic [7:0] address_reset = 8'h00;
endpackage
`default_nettype wire

// ==== logic/ssf_flags.sv ====
/*
 status and control flag logic of a synchronous serial port (spi master or
 slave, i2c slave), with an apb register slave and one level interrupt.
 assumes a bit engine outside that shifts the data and reports one-cycle
 event pulses synchronous to clk; apb master per amba apb protocol.
*/
// Overview of operation
// R01: i2c: capture read/write bit at address match; drop at start, stop or ack.
// R02: 10-bit i2c: set update-address flag when address register must be reloaded.
// R03: completed reception loads the buffer and sets buffer-full in spi and i2c.
// R04: i2c transmit: buffer-full high while eight loaded bits send, low when done.
// R05: buffer write while busy is rejected and sets write-collision until software clears.
// R06: software read of the data buffer clears buffer-full.
`timescale 1ns/100ps
`default_nettype none
module ssf_flags #(
	parameter int addr_w = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [addr_w-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic eng_busy,
	input wire logic eng_addr_match,
	input wire logic eng_rw,
	input wire logic eng_start,
	input wire logic eng_stop,
	input wire logic eng_ack,
	input wire logic eng_update_address,
	input wire logic eng_rx_done,
	input wire logic [7:0] eng_rx_data,
	input wire logic eng_tx_done,
	output logic tx_load,
	output logic [7:0] tx_data,
	output logic [7:0] slave_address,
	output logic port_enable_bit,
	output logic clock_polarity_bit,
	output logic [3:0] port_mode,
	output logic irq
);
	// offsets need at least one full byte of address
	if (addr_w < 8) begin
		$error("ssf_flags: addr_w must be at least 8");
	end

	// -------------------------------------------------------------
	// reset release
	// -------------------------------------------------------------
	logic [1:0] rst_sync;
	logic rst_q_n;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_q_n = rst_sync[1];

	// -------------------------------------------------------------
	// apb decode
	// -------------------------------------------------------------
	logic [7:0] off;
	logic done;
	logic wr;
	logic rd;
	logic mapped;
	assign off = paddr[7:0];
	assign done = psel && penable && pready;
	// unmapped writes must have no effect anywhere
	assign wr = done && pwrite && mapped;
	assign rd = done && !pwrite;
	assign mapped = ((paddr >> 8) == '0) && (off == ssf_pkg::off_status
		|| off == ssf_pkg::off_control || off == ssf_pkg::off_data
		|| off == ssf_pkg::off_address || off == ssf_pkg::off_int_status
		|| off == ssf_pkg::off_int_mask);

	logic [7:0] control;
	logic [7:0] data_buf;
	logic rw_flag;
	logic update_address_flag;
	logic buffer_full_flag;
	logic [ssf_pkg::irq_count-1:0] int_status;
	logic [ssf_pkg::irq_count-1:0] int_mask;

	logic i2c_mode;
	logic ten_bit_mode;
	logic data_wr;
	logic data_wr_ok;
	logic collision;
	assign i2c_mode = control[ssf_pkg::ct_port_enable_bit]
		&& control[3:1] == ssf_pkg::mode_i2c_prefix;
	assign ten_bit_mode = i2c_mode && control[3:0] == ssf_pkg::mode_i2c_10bit;
	assign data_wr = wr && off == ssf_pkg::off_data;
	assign collision = data_wr && eng_busy; // R05
	assign data_wr_ok = data_wr && !eng_busy; // R05

	// -------------------------------------------------------------
	// bus answer: one wait state, registered
	// -------------------------------------------------------------
	logic [31:0] next_prdata;
	always_comb begin
		next_prdata = 32'h0000_0000;
		case (off)
			ssf_pkg::off_status: begin
				next_prdata[ssf_pkg::st_rw_bit] = rw_flag;
				next_prdata[ssf_pkg::st_update_address_flag] = update_address_flag;
				next_prdata[ssf_pkg::st_buffer_full_flag] = buffer_full_flag;
			end
			ssf_pkg::off_control: next_prdata[7:0] = control;
			ssf_pkg::off_data: next_prdata[7:0] = data_buf;
			ssf_pkg::off_address: next_prdata[7:0] = slave_address;
			ssf_pkg::off_int_status: next_prdata[ssf_pkg::irq_count-1:0] = int_status;
			ssf_pkg::off_int_mask: next_prdata[ssf_pkg::irq_count-1:0] = int_mask;
			default: next_prdata = 32'h0000_0000;
		endcase
		if (!mapped) begin
			next_prdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			if (psel && penable && !pready) begin
				prdata <= next_prdata;
			end
		end
	end

	// -------------------------------------------------------------
	// control register and write collision
	// -------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			control <= ssf_pkg::control_reset;
		end else begin
			if (wr && mapped && off == ssf_pkg::off_control) begin
				control[6:0] <= pwdata[6:0];
				if (!pwdata[ssf_pkg::ct_write_collision_flag]) begin
					control[ssf_pkg::ct_write_collision_flag] <= 1'b0; // R05
				end
			end
			if (collision) begin
				control[ssf_pkg::ct_write_collision_flag] <= 1'b1; // R05
			end
		end
	end

	always_ff @(posedge clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			port_enable_bit <= 1'b0;
			clock_polarity_bit <= 1'b0;
			port_mode <= 4'h0;
		end else begin
			port_enable_bit <= control[ssf_pkg::ct_port_enable_bit];
			clock_polarity_bit <= control[ssf_pkg::ct_clock_polarity_bit];
			port_mode <= control[3:0];
		end
	end

	// -------------------------------------------------------------
	// data buffer and transmit load
	// -------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			data_buf <= ssf_pkg::data_reset;
			tx_load <= 1'b0;
			tx_data <= ssf_pkg::data_reset;
		end else begin
			tx_load <= data_wr_ok && mapped;
			// transmit byte follows the accepted write even when rx wins the buffer
			if (data_wr_ok) begin
				tx_data <= pwdata[7:0];
			end
			if (eng_rx_done) begin
				data_buf <= eng_rx_data; // R03
			end else if (data_wr_ok) begin
				data_buf <= pwdata[7:0]; // R05
			end
		end
	end

	// -------------------------------------------------------------
	// status flags
	// -------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			buffer_full_flag <= 1'b0;
		end else begin
			if (rd && off == ssf_pkg::off_data) begin
				buffer_full_flag <= 1'b0; // R06
			end else if (eng_tx_done && i2c_mode) begin
				buffer_full_flag <= 1'b0; // R04
			end
			if (eng_rx_done) begin
				buffer_full_flag <= 1'b1; // R03
			end else if (data_wr_ok && i2c_mode) begin
				buffer_full_flag <= 1'b1; // R04
			end
		end
	end

	always_ff @(posedge clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			rw_flag <= 1'b0;
		end else if (i2c_mode && eng_addr_match) begin
			rw_flag <= eng_rw; // R01
		end else if (eng_start || eng_stop || eng_ack) begin
			rw_flag <= 1'b0; // R01
		end
	end

	always_ff @(posedge clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			update_address_flag <= 1'b0;
			slave_address <= ssf_pkg::address_reset;
		end else begin
			if (wr && off == ssf_pkg::off_address) begin
				slave_address <= pwdata[7:0];
				update_address_flag <= 1'b0; // R02
			end
			if (ten_bit_mode && eng_update_address) begin
				update_address_flag <= 1'b1; // R02
			end
		end
	end

	// -------------------------------------------------------------
	// interrupts: sticky, write one to clear, set wins
	// -------------------------------------------------------------
	logic [ssf_pkg::irq_count-1:0] events;
	assign events[ssf_pkg::irq_rx_done] = eng_rx_done;
	assign events[ssf_pkg::irq_tx_done] = eng_tx_done;
	assign events[ssf_pkg::irq_collision] = collision;
	assign events[ssf_pkg::irq_update_address] = ten_bit_mode && eng_update_address;

	always_ff @(posedge clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			int_status <= '0;
			int_mask <= '0;
			irq <= 1'b0;
		end else begin
			if (wr && off == ssf_pkg::off_int_status) begin
				int_status <= (int_status & ~pwdata[ssf_pkg::irq_count-1:0]) | events;
			end else begin
				int_status <= int_status | events;
			end
			if (wr && off == ssf_pkg::off_int_mask) begin
				int_mask <= pwdata[ssf_pkg::irq_count-1:0];
			end
			irq <= |(int_status & int_mask);
		end
	end
endmodule
`default_nettype wire

// ==== testbench/ssf_props.sv ====
/*
 port checks of ssf_flags: apb timing, buffer load and refusal, mode copy.
 assumes one clk domain with rst_n as its reset.
*/
`timescale 1ns/100ps
`default_nettype none
module ssf_props #(
	parameter int addr_w = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [addr_w-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic eng_busy,
	input wire logic tx_load,
	input wire logic [3:0] port_mode
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic acc, wd, wc;
	logic [3:0] wm;
	assign acc = psel && penable && pready && pwrite;
	assign wd = acc && paddr == addr_w'(ssf_pkg::off_data);
	assign wc = acc && paddr == addr_w'(ssf_pkg::off_control);
	assign wm = pwdata[3:0];
	sequence s_wait;
		!pready ##1 pready;
	endsequence
	a_one_wait: assert property ($rose(penable) && psel |-> s_wait)
		else $error("no single wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready too long");
	a_idle_quiet: assert property (!psel |-> !pready)
		else $error("pready while idle");
	a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("bad error answer");
	a_buf_load: assert property (wd && !eng_busy |=> tx_load)
		else $error("buffer write not loaded");
	a_write_refused: assert property (wd && eng_busy |=> !tx_load)
		else $error("busy write loaded");
	a_load_pulse: assert property (tx_load |=> !tx_load)
		else $error("load too long");
	a_mode_copy: assert property (wc |-> ##2 port_mode == $past(wm, 2))
		else $error("mode copy wrong");
endmodule
bind ssf_flags ssf_props #(.addr_w(addr_w)) u_props (.clk(clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .eng_busy(eng_busy), .tx_load(tx_load),
	.port_mode(port_mode));
`default_nettype wire

// ==== testbench/ssf_engine_model.sv ====
/*
 engine-side partner: one-cycle event pulses with direction and byte.
 assumes fire is called right after a rising edge of clk.
*/
`timescale 1ns/100ps
`default_nettype none
module ssf_engine_model (
	input wire logic clk,
	output logic [6:0] ev,
	output logic rw,
	output logic [7:0] dat
);
	initial begin
		ev = 7'h00;
		rw = 1'b0;
		dat = 8'h00;
	end
	// 0 match, 1 start, 2 stop, 3 ack, 4 update, 5 rx, 6 tx; stale values inverted
	task automatic fire(input int k, input logic v, input logic [7:0] d);
		@(posedge clk);
		ev[k] <= 1'b1;
		rw <= v;
		dat <= d;
		@(posedge clk);
		ev <= 7'h00;
		rw <= ~v;
		dat <= ~d;
	endtask
endmodule
`default_nettype wire

// ==== testbench/ssf_flags_tb_top.sv ====
/*
 self-checking bench of ssf_flags: apb master, engine partner, checks.
 assumes ssf_pkg, the engine model and the bound checker are compiled.
*/
`timescale 1ns/100ps
`default_nettype none
module ssf_flags_tb_top;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, busy = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, e, irq, rw, pe, cp;
	logic [3:0] pm;
	logic [7:0] tx_data, sa, dat, r;
	logic [6:0] ev;
	int error_cnt = 0, compares = 0;
	initial forever #12.5 clk = ~clk;
	ssf_engine_model u_eng (.clk(clk), .ev(ev), .rw(rw), .dat(dat));
	ssf_flags u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .eng_busy(busy), .eng_addr_match(ev[0]), .eng_rw(rw),
		.eng_start(ev[1]), .eng_stop(ev[2]), .eng_ack(ev[3]), .eng_update_address(ev[4]),
		.eng_rx_done(ev[5]), .eng_rx_data(dat), .eng_tx_done(ev[6]), .tx_load(),
		.tx_data(tx_data), .slave_address(sa), .port_enable_bit(pe), .clock_polarity_bit(cp),
		.port_mode(pm), .irq(irq));
	function automatic logic [31:0] st(input logic w, u, b);
		return {29'h0, w, u, b};
	endfunction
	task automatic conclude();
		if (error_cnt == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, x);
		compares++;
		if (g !== x) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] x);
		xfer(1'b0, a, 32'h0);
		chk(q, x);
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		conclude();
	end
	initial begin
		r = 8'($urandom(66281));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rc(ssf_pkg::off_control, 32'h0);
		rc(ssf_pkg::off_status, st(0, 0, 0));
		xfer(1'b0, 8'h18, 32'h0);
		chk({31'h0, e}, 32'h1);
		xfer(1'b1, ssf_pkg::off_control, 32'h37);
		for (int k = 1; k < 4; k++) begin
			u_eng.fire(0, 1'b1, 8'h00);
			rc(ssf_pkg::off_status, st(1, 0, 0));
			u_eng.fire(k, 1'b0, 8'h00);
			rc(ssf_pkg::off_status, st(0, 0, 0));
		end
		chk({26'h0, pe, cp, pm}, 32'h37);
		u_eng.fire(4, 1'b0, 8'h00);
		rc(ssf_pkg::off_status, st(0, 1, 0));
		chk({31'h0, irq}, 32'h0);
		xfer(1'b1, ssf_pkg::off_address, {24'h0, r});
		rc(ssf_pkg::off_status, st(0, 0, 0));
		chk({24'h0, sa}, {24'h0, r});
		xfer(1'b1, ssf_pkg::off_int_mask, 32'h1);
		r = 8'($urandom);
		u_eng.fire(5, 1'b0, r);
		rc(ssf_pkg::off_status, st(0, 0, 1));
		chk({31'h0, irq}, 32'h1);
		rc(ssf_pkg::off_data, {24'h0, r});
		rc(ssf_pkg::off_status, st(0, 0, 0));
		rc(ssf_pkg::off_int_status, 32'h9);
		xfer(1'b1, ssf_pkg::off_int_status, 32'hf);
		rc(ssf_pkg::off_int_status, 32'h0);
		chk({31'h0, irq}, 32'h0);
		r = 8'($urandom);
		xfer(1'b1, ssf_pkg::off_data, {24'h0, r});
		rc(ssf_pkg::off_status, st(0, 0, 1));
		chk({24'h0, tx_data}, {24'h0, r});
		u_eng.fire(6, 1'b0, 8'h00);
		rc(ssf_pkg::off_status, st(0, 0, 0));
		busy <= 1'b1;
		xfer(1'b1, ssf_pkg::off_data, 32'h5a);
		rc(ssf_pkg::off_control, 32'hb7);
		rc(ssf_pkg::off_status, st(0, 0, 0));
		rc(ssf_pkg::off_int_status, 32'h6);
		busy <= 1'b0;
		xfer(1'b1, ssf_pkg::off_control, 32'h20);
		rc(ssf_pkg::off_control, 32'h20);
		chk({26'h0, pe, cp, pm}, 32'h20);
		u_eng.fire(0, 1'b1, 8'h00);
		u_eng.fire(5, 1'b0, 8'h3c);
		rc(ssf_pkg::off_status, st(0, 0, 1));
		conclude();
	end
endmodule
`default_nettype wire
